// >>> hfck_pkg.sv
// shared constants for the clock status and fast oscillator trim block
package hfck_pkg;
  // register offsets (byte addresses, printed offsets not all multiples of four -> index*4)
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h04;
  localparam logic [7:0] IDX_STATUS      = 8'h05;
  localparam logic [7:0] IDX_TIMEBASE    = 8'h06;
  localparam logic [7:0] IDX_OSC_CTRL    = 8'h08;
  localparam logic [7:0] IDX_OSC_TRIM    = 8'h09;
  localparam logic [7:0] IDX_TRIM_STATUS = 8'h0A;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h0B;
  localparam logic [9:0] ADDR_IRQ_FLAGS   = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_STATUS      = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_TIMEBASE    = {IDX_TIMEBASE, 2'b00};
  localparam logic [9:0] ADDR_OSC_CTRL    = {IDX_OSC_CTRL, 2'b00};
  localparam logic [9:0] ADDR_OSC_TRIM    = {IDX_OSC_TRIM, 2'b00};
  localparam logic [9:0] ADDR_TRIM_STATUS = {IDX_TRIM_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK    = {IDX_IRQ_MASK, 2'b00};
  // reset values
  localparam logic [7:0] RST_OSC_CTRL = 8'h0C;
  localparam logic [4:0] RST_TIMEBASE = 5'h00;
  localparam logic [6:0] RST_TRIM     = 7'h00;
  // field positions
  localparam int BIT_KEEP_RUN  = 7;
  localparam int BIT_METHOD    = 6;
  localparam int FRQ_HI        = 5;
  localparam int FRQ_LO        = 2;
  localparam int BIT_TRIM_SIGN = 5;
  // auto-trim source codes
  localparam logic [1:0] AUTO_OFF   = 2'h0;
  localparam logic [1:0] AUTO_SLOW  = 2'h1;
  localparam logic [1:0] AUTO_FRAME = 2'h2;
  // trim reload wait after auto-trim off: 3 us plus 3 main cycles, 153 cycles at 50 MHz
  localparam int CLK_MHZ        = 50;
  localparam int RELOAD_US      = 3;
  localparam int RELOAD_EXTRA   = 3;
  localparam int RELOAD_CYCLES  = RELOAD_US * CLK_MHZ + RELOAD_EXTRA;
  localparam int GRANT_OSC_CYC  = 2;   // osc edges before output granted
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : hfck_pkg

// >>> hfck_sync_if.sv
`timescale 1ns/1ns
// carrier between the top and the two-flop synchroniser bank
interface hfck_sync_if;
  logic [9:0] raw;
  logic [9:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface : hfck_sync_if

// >>> hfck_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser bank for asynchronous status inputs
module hfck_sync (
  input  wire logic   clock,
  input  wire logic   srst,
  hfck_sync_if.snk    bus
);
  logic [9:0] stage1;
  logic [9:0] stage2;
  // first stage is read only by the second
  always_ff @(posedge clock) begin
    if (srst) begin
      stage1 <= 10'h000;
      stage2 <= 10'h000;
    end else begin
      stage1 <= bus.raw;
      stage2 <= stage1;
    end
  end
  assign bus.synced = stage2;
endmodule : hfck_sync

// >>> hfck_top.sv
`timescale 1ns/1ns
// clock status, microsecond timebase and fast oscillator trim registers
// Notes on behaviour
// R1: clock failure sets flag, write one clears
// R2: bit 4 shows external fast source ok
// R3: bit 3 shows external slow source ok
// R4: bits 2,1 show internal oscillators stable
// R5: bit 0 high while main source switches
// R6: five-bit timebase cycles per microsecond
// R7: keep-running bit forces oscillator on
// R8: output granted two oscillator cycles after request
// R9: method bit picks binary or incremental search
// R10: software writes method with frame source
// R11: binary search may shift frequency temporarily
// R12: frequency select field, reset 0x3
// R13: auto-trim source off, slow crystal, frame
// R14: signed trim from -32 to +31
// R15: trim bit 6 mirrors bit 5
// R16: nonzero auto source locks manual trim
// R17: trim reloads from auto value after disable
// R18: sync bit low while auto source crosses
// R19: lock bit shows tuner locked
module hfck_top (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        clock_fail_event,
  input  wire logic        fast_ext_source_kind,
  input  wire logic        ext_hf_crystal_stable,
  input  wire logic        ext_hf_clock_running,
  input  wire logic        slow_ext_source_kind,
  input  wire logic        ext_slow_crystal_stable,
  input  wire logic        ext_slow_clock_running,
  input  wire logic        int_slow_osc_stable,
  input  wire logic        int_fast_osc_stable,
  input  wire logic        source_switch_active,
  input  wire logic        osc_request,
  input  wire logic        osc_edge,
  input  wire logic [6:0]  auto_trim_value,
  input  wire logic        tuner_locked,
  input  wire logic        tuner_sync_ack,
  output logic             osc_enable,
  output logic             osc_grant,
  output logic             keep_running_in_sleep,
  output logic             tune_method_select,
  output logic [3:0]       freq_select,
  output logic [1:0]       auto_trim_source,
  output logic [6:0]       manual_trim,
  output logic [4:0]       microsecond_base,
  output logic             irq
);
  // ---------------- synchronisers ----------------
  hfck_sync_if sif ();
  assign sif.raw = {tuner_sync_ack, tuner_locked, osc_edge, source_switch_active,
                    int_fast_osc_stable, int_slow_osc_stable, ext_slow_clock_running,
                    ext_slow_crystal_stable, ext_hf_clock_running, ext_hf_crystal_stable};
  hfck_sync u_sync (
    .clock (clock),
    .srst  (srst),
    .bus   (sif.snk)
  );
  wire s_hf_xtal  = sif.synced[0];
  wire s_hf_clk   = sif.synced[1];
  wire s_sl_xtal  = sif.synced[2];
  wire s_sl_clk   = sif.synced[3];
  wire s_int_slow = sif.synced[4];
  wire s_int_fast = sif.synced[5];
  wire s_switch   = sif.synced[6];
  wire s_osc_edge = sif.synced[7];
  wire s_locked   = sif.synced[8];
  wire s_sync_ack = sif.synced[9];

  // ---------------- register state ----------------
  logic       clock_fail_flag;
  logic       irq_mask;
  logic [4:0] timebase;
  logic [7:0] osc_ctrl;
  logic [6:0] trim;
  logic       trim_sync_done;
  logic       sync_seen_ack;
  logic       osc_ev_d;
  logic [1:0] grant_cnt;
  logic [7:0] reload_cnt;
  logic       reload_busy;
  logic       fail_d;

  // ---------------- axi write channel ----------------
  logic       aw_held;
  logic       w_held;
  logic [9:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_fire;
  wire have_w  = w_held || w_fire;
  wire [9:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_go  = have_aw && have_w && !s_axi_bvalid;
  wire wr_lane = wr_go && wr_strb[0];

  // address decode, shared by read and write
  function automatic logic addr_known(input logic [9:0] a);
    addr_known = (a == hfck_pkg::ADDR_IRQ_FLAGS) || (a == hfck_pkg::ADDR_STATUS) ||
                 (a == hfck_pkg::ADDR_TIMEBASE) || (a == hfck_pkg::ADDR_OSC_CTRL) ||
                 (a == hfck_pkg::ADDR_OSC_TRIM) || (a == hfck_pkg::ADDR_TRIM_STATUS) ||
                 (a == hfck_pkg::ADDR_IRQ_MASK);
  endfunction : addr_known

  wire wr_flags = wr_lane && (wr_addr == hfck_pkg::ADDR_IRQ_FLAGS);
  wire wr_tb    = wr_lane && (wr_addr == hfck_pkg::ADDR_TIMEBASE);
  wire wr_ctrl  = wr_lane && (wr_addr == hfck_pkg::ADDR_OSC_CTRL);
  wire wr_trim  = wr_lane && (wr_addr == hfck_pkg::ADDR_OSC_TRIM);
  wire wr_mask  = wr_lane && (wr_addr == hfck_pkg::ADDR_IRQ_MASK);
  wire [7:0] wb = wr_data[7:0];

  // hold whichever half arrived first
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 10'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_fire && !wr_go) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (w_fire && !wr_go) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= hfck_pkg::AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_known(wr_addr) ? hfck_pkg::AXI_OKAY : hfck_pkg::AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- control registers ----------------
  wire auto_on   = osc_ctrl[1:0] != hfck_pkg::AUTO_OFF;
  wire auto_off_now = wr_ctrl && auto_on && (wb[1:0] == hfck_pkg::AUTO_OFF);

  // clock failure flag: set beats clear
  always_ff @(posedge clock) begin
    if (srst) begin
      fail_d          <= 1'b0;
      clock_fail_flag <= 1'b0;
      irq_mask        <= 1'b0;
      timebase        <= hfck_pkg::RST_TIMEBASE;
      osc_ctrl        <= hfck_pkg::RST_OSC_CTRL;
    end else begin
      fail_d <= clock_fail_event;
      if (clock_fail_event && !fail_d)
        clock_fail_flag <= 1'b1;                     // see R1
      else if (wr_flags && wb[0])
        clock_fail_flag <= 1'b0;                     // see R1
      if (wr_mask)
        irq_mask <= wb[0];
      if (wr_tb)
        timebase <= wb[4:0];                         // see R6
      if (wr_ctrl)
        osc_ctrl <= wb;                              // see R9 R12 R13
    end
  end

  // trim: locked while auto on, reloaded from tuner after disable
  always_ff @(posedge clock) begin
    if (srst) begin
      trim        <= hfck_pkg::RST_TRIM;
      reload_busy <= 1'b0;
      reload_cnt  <= 8'h00;
    end else begin
      if (auto_off_now) begin
        reload_busy <= 1'b1;
        reload_cnt  <= 8'(hfck_pkg::RELOAD_CYCLES - 1);
      end else if (reload_busy) begin
        if (reload_cnt == 8'h00) begin
          reload_busy <= 1'b0;
          trim <= {auto_trim_value[hfck_pkg::BIT_TRIM_SIGN],
                   auto_trim_value[5:0]};            // see R17 R15
        end else begin
          reload_cnt <= reload_cnt - 8'h01;
        end
      end else if (wr_trim && !auto_on) begin         // see R16
        trim <= {wb[hfck_pkg::BIT_TRIM_SIGN], wb[5:0]}; // see R14 R15
      end
    end
  end

  // auto source sync: low from a write until tuner acknowledges
  always_ff @(posedge clock) begin
    if (srst) begin
      trim_sync_done <= 1'b1;
      sync_seen_ack  <= 1'b0;
    end else if (wr_ctrl) begin
      trim_sync_done <= 1'b0;                        // see R18
      sync_seen_ack  <= s_sync_ack;
    end else if (!trim_sync_done && (s_sync_ack != sync_seen_ack)) begin
      trim_sync_done <= 1'b1;                        // see R18
    end
  end

  // oscillator enable and grant after two oscillator edges
  wire osc_run = osc_ctrl[hfck_pkg::BIT_KEEP_RUN] || osc_request; // see R7
  wire osc_tick = s_osc_edge && !osc_ev_d;
  always_ff @(posedge clock) begin
    if (srst) begin
      osc_ev_d  <= 1'b0;
      grant_cnt <= 2'h0;
      osc_grant <= 1'b0;
    end else begin
      osc_ev_d <= s_osc_edge;
      if (!osc_request) begin
        grant_cnt <= 2'h0;
        osc_grant <= 1'b0;
      end else if (osc_tick && !osc_grant) begin
        if (grant_cnt == 2'(hfck_pkg::GRANT_OSC_CYC - 1))
          osc_grant <= 1'b1;                         // see R8
        grant_cnt <= grant_cnt + 2'h1;
      end
    end
  end
  assign osc_enable = osc_run;

  // status assembly
  wire hf_ok   = fast_ext_source_kind ? s_hf_clk : s_hf_xtal;  // see R2
  wire slow_ok = slow_ext_source_kind ? s_sl_clk : s_sl_xtal;  // see R3
  wire [7:0] status_byte = {3'b000, hf_ok, slow_ok, s_int_slow, s_int_fast,
                            s_switch};                 // see R4 R5

  // ---------------- axi read channel ----------------
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  logic [7:0] rd_byte;
  always_comb begin
    case (s_axi_araddr)
      hfck_pkg::ADDR_IRQ_FLAGS:   rd_byte = {7'h00, clock_fail_flag};
      hfck_pkg::ADDR_STATUS:      rd_byte = status_byte;
      hfck_pkg::ADDR_TIMEBASE:    rd_byte = {3'h0, timebase};
      hfck_pkg::ADDR_OSC_CTRL:    rd_byte = osc_ctrl;
      hfck_pkg::ADDR_OSC_TRIM:    rd_byte = {1'b0, trim};
      hfck_pkg::ADDR_TRIM_STATUS: rd_byte = {6'h00, s_locked, trim_sync_done}; // see R19
      hfck_pkg::ADDR_IRQ_MASK:    rd_byte = {7'h00, irq_mask};
      default:                    rd_byte = 8'h00;
    endcase
  end

  // read data registered; unmapped answers zero with error
  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= hfck_pkg::AXI_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= addr_known(s_axi_araddr) ? hfck_pkg::AXI_OKAY : hfck_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // outputs to the oscillator and tuner; method bit only meaningful with frame source
  assign keep_running_in_sleep = osc_ctrl[hfck_pkg::BIT_KEEP_RUN];
  assign tune_method_select    = osc_ctrl[hfck_pkg::BIT_METHOD];  // see R9 R11
  assign freq_select           = osc_ctrl[hfck_pkg::FRQ_HI:hfck_pkg::FRQ_LO];
  assign auto_trim_source      = osc_ctrl[1:0];
  assign manual_trim           = trim;
  assign microsecond_base      = timebase;
  assign irq                   = clock_fail_flag && irq_mask;
endmodule : hfck_top

// >>> hfck_properties.sv
// concurrent checks on the top-level ports of the fast oscillator trim block
`timescale 1ns/1ns
module hfck_properties (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       osc_request,
  input wire logic       osc_enable,
  input wire logic       osc_grant,
  input wire logic       keep_running_in_sleep,
  input wire logic [3:0] freq_select,
  input wire logic [1:0] auto_trim_source,
  input wire logic [6:0] manual_trim,
  input wire logic [6:0] auto_trim_value
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  run_enable_a: assert property (osc_enable == (keep_running_in_sleep | osc_request))
    else $error("oscillator enable mismatch");
  grant_cause_a: assert property ($rose(osc_grant) |-> $past(osc_request, 2))
    else $error("grant without held request");
  grant_drop_a: assert property (!osc_request |=> !osc_grant)
    else $error("grant outlived request");
  trim_mirror_a: assert property (manual_trim[6] == manual_trim[5])
    else $error("trim sign not mirrored");
  trim_locked_a: assert property (auto_trim_source != 2'h0 |=> $stable(manual_trim))
    else $error("trim moved while locked");
  // reload may land any time up to 160 cycles, a little past the 3 us plus 3 cycle wait
  trim_reload_a: assert property (($past(auto_trim_source) != 2'h0 && auto_trim_source == 2'h0)
    |-> ##[1:160] (manual_trim == {auto_trim_value[5], auto_trim_value[5:0]}))
    else $error("trim not reloaded in time");
  ctrl_reset_a: assert property (disable iff (1'b0) srst |=> (freq_select == 4'h3
    && auto_trim_source == 2'h0 && !keep_running_in_sleep && manual_trim == 7'h00))
    else $error("control reset value wrong");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule : hfck_properties

bind hfck_top hfck_properties i_props (.*);

// >>> test_main_clock_status_and_hf_osc_tune.sv
// self-checking bench for the clock status and fast oscillator trim block
`timescale 1ns/1ns
module test_main_clock_status_and_hf_osc_tune;
  logic        clock, srst, clock_fail_event, osc_request, osc_edge, tuner_locked;
  logic        tuner_sync_ack, osc_enable, osc_grant, keep_running_in_sleep, irq;
  logic        tune_method_select, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb, freq_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, auto_trim_source, rsp;
  logic [6:0]  auto_trim_value, manual_trim, tv;
  logic [4:0]  microsecond_base;
  logic [8:0]  st;
  logic [7:0]  d;
  int          failures, samples_checked, seed, i;

  // status sources come from one vector so they can be drawn together
  hfck_top i_dut (.*, .fast_ext_source_kind(st[8]), .ext_hf_crystal_stable(st[7]),
    .ext_hf_clock_running(st[6]), .slow_ext_source_kind(st[5]),
    .ext_slow_crystal_stable(st[4]), .ext_slow_clock_running(st[3]),
    .int_slow_osc_stable(st[2]), .int_fast_osc_stable(st[1]), .source_switch_active(st[0]));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // oscillator edge marker, one toggle per cycle
  always @(posedge clock) osc_edge <= ~osc_edge;

  // expected status byte from raw source levels and source kinds
  function automatic logic [31:0] exp_st(input logic [8:0] v);
    return {27'h0, v[8] ? v[6] : v[7], v[5] ? v[3] : v[4], v[2:0]};
  endfunction : exp_st

  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t response %b want %b", $time, got, exp);
    end
  endtask : chk_r

  // ready is sampled before the edge updates land, so the handshake is seen as the slave saw it
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 64);
    rsp = s_axi_bresp;
    if (s_axi_bvalid !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask : wr

  task automatic rd(input logic [9:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 64);
    rd_data = s_axi_rdata;
    rsp = s_axi_rresp;
    if (s_axi_rvalid !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask : rd

  task automatic rc(input logic [9:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
  endtask : rc

  // main sequence
  initial begin
    seed = 32'hF2CB0E5F;
    failures = 0;
    samples_checked = 0;
    srst = 1'b1;
    {clock_fail_event, osc_request, osc_edge, tuner_locked, tuner_sync_ack} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    st = 9'h000;
    auto_trim_value = 7'h2A;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rc(hfck_pkg::ADDR_IRQ_FLAGS, 32'h00);
    rc(hfck_pkg::ADDR_STATUS, 32'h00);
    rc(hfck_pkg::ADDR_TIMEBASE, 32'h00);
    rc(hfck_pkg::ADDR_OSC_CTRL, 32'h0C);
    rc(hfck_pkg::ADDR_OSC_TRIM, 32'h00);
    rc(10'h3FC, 32'h00);
    chk_r(rsp, hfck_pkg::AXI_SLVERR);
    wr(10'h3FC, 8'hFF);
    chk_r(rsp, hfck_pkg::AXI_SLVERR);
    $display("reset and decode test done");
    // status follows the sources; a write to it must not stick
    wr(hfck_pkg::ADDR_STATUS, 8'hFF);
    for (i = 0; i < 24; i++) begin
      st <= (i == 0) ? 9'h155 : 9'($random(seed));
      repeat (4) @(posedge clock);
      rc(hfck_pkg::ADDR_STATUS, exp_st(st));
    end
    $display("status test done");
    clock_fail_event <= 1'b1;
    @(posedge clock);
    clock_fail_event <= 1'b0;
    rc(hfck_pkg::ADDR_IRQ_FLAGS, 32'h01);
    chk({31'h0, irq}, 32'h0);
    wr(hfck_pkg::ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(hfck_pkg::ADDR_IRQ_FLAGS, 8'h00);
    rc(hfck_pkg::ADDR_IRQ_FLAGS, 32'h01);
    wr(hfck_pkg::ADDR_IRQ_FLAGS, 8'h01);
    rc(hfck_pkg::ADDR_IRQ_FLAGS, 32'h00);
    chk({31'h0, irq}, 32'h0);
    $display("clock failure test done");
    for (i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h1F : 8'($random(seed));
      wr(hfck_pkg::ADDR_TIMEBASE, d);
      rc(hfck_pkg::ADDR_TIMEBASE, {27'h0, d[4:0]});
      chk({27'h0, microsecond_base}, {27'h0, d[4:0]});
      if (i != 4) begin
        d = {2'($random(seed)), 4'(i), hfck_pkg::AUTO_OFF};
        osc_request <= 1'($random(seed));
        wr(hfck_pkg::ADDR_OSC_CTRL, d);
        rc(hfck_pkg::ADDR_OSC_CTRL, {24'h0, d});
        chk({24'h0, keep_running_in_sleep, tune_method_select, freq_select,
             auto_trim_source}, {24'h0, d});
      end
    end
    // bit 6 is drawn too, it must follow bit 5
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h20 : (i == 1) ? 8'h5F : 8'($random(seed)) & 8'h7F;
      tv = {d[5], d[5:0]};
      wr(hfck_pkg::ADDR_OSC_TRIM, d);
      rc(hfck_pkg::ADDR_OSC_TRIM, {25'h0, tv});
    end
    $display("register test done");
    wr(hfck_pkg::ADDR_OSC_CTRL, {6'h03, hfck_pkg::AUTO_SLOW});
    rc(hfck_pkg::ADDR_OSC_CTRL, {26'h0, 4'h3, hfck_pkg::AUTO_SLOW});
    wr(hfck_pkg::ADDR_OSC_TRIM, 8'h05);
    rc(hfck_pkg::ADDR_OSC_TRIM, {25'h0, tv});
    wr(hfck_pkg::ADDR_OSC_CTRL, {6'h13, hfck_pkg::AUTO_FRAME});
    rc(hfck_pkg::ADDR_TRIM_STATUS, 32'h0);
    tuner_sync_ack <= 1'b1;
    tuner_locked <= 1'b1;
    repeat (4) @(posedge clock);
    rc(hfck_pkg::ADDR_TRIM_STATUS, 32'h3);
    wr(hfck_pkg::ADDR_OSC_CTRL, {6'h03, hfck_pkg::AUTO_OFF});
    repeat (170) @(posedge clock);
    chk({25'h0, manual_trim}, 32'h6A);
    $display("auto trim test done");
    osc_request <= 1'b1;
    repeat (12) @(posedge clock);
    chk({31'h0, osc_grant}, 32'h1);
    osc_request <= 1'b0;
    repeat (2) @(posedge clock);
    chk({31'h0, osc_grant}, 32'h0);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rc(hfck_pkg::ADDR_OSC_CTRL, 32'h0C);
    $display("grant and second reset test done");
    conclude();
  end
endmodule : test_main_clock_status_and_hf_osc_tune
